//--- logic/wdg_consts.svh
`ifndef WDG_CONSTS_SVH
`define WDG_CONSTS_SVH

// Register indices; the byte address is four times the index.
`define WDG_IDX_CONTROL 6'h00
`define WDG_IDX_STATUS 6'h01
`define WDG_IDX_UNLOCK 6'h02

// Field positions.
`define WDG_WIN_MSB 7
`define WDG_WIN_LSB 4
`define WDG_PER_MSB 3
`define WDG_PER_LSB 0
`define WDG_LOCK_BIT 7
`define WDG_CLR_BUSY_BIT 1
`define WDG_SYNC_BUSY_BIT 0

// Reset values.
`define WDG_STATUS_RESET 8'h00
`define WDG_CONTROL_RESET 8'h00

// Time-out codes: code n gives BASE << (n - 1) watchdog clocks.
`define WDG_CODE_MAX 4'hB
`define WDG_BASE_TICKS 14'h0008

// Timing.
`define WDG_CLK_PERIOD_NS 20
`define WDG_OSC_PERIOD_US 1000
`define WDG_TICK_DIV ((`WDG_OSC_PERIOD_US * 1000) / `WDG_CLK_PERIOD_NS)
`define WDG_SYNC_TICKS 2'h2
`define WDG_UNLOCK_INSNS 4
`define WDG_CYC_PER_INSN 4
`define WDG_UNLOCK_CYCLES (`WDG_UNLOCK_INSNS * `WDG_CYC_PER_INSN)

// Unlock key value is arbitrary.
`define WDG_UNLOCK_KEY 8'h5A

// AXI responses.
`define WDG_RESP_OKAY 2'h0
`define WDG_RESP_SLVERR 2'h2

`endif

//--- logic/wdg_pkg.sv
`include "wdg_consts.svh"

package wdg_pkg;

  typedef enum logic [4:0] {
    ST_OFF = 5'b00001,
    ST_NORMAL = 5'b00010,
    ST_FIRST = 5'b00100,
    ST_CLOSED = 5'b01000,
    ST_OPEN = 5'b10000
  } wdg_state_t;

  typedef enum logic [1:0] {
    SEL_CTRL = 2'h0,
    SEL_STATUS = 2'h1,
    SEL_UNLOCK = 2'h2,
    SEL_NONE = 2'h3
  } wdg_sel_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } wdg_tick_st_t;

  typedef struct packed {
    logic busy;
    logic [1:0] cnt;
    logic done;
  } wdg_sync_st_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_got;
    wdg_sel_t aw_sel;
    logic w_got;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic booted;
    logic cfg_apply;
    logic [7:0] ctrl;
    logic [7:0] ctrl_wd;
    logic lock;
    logic [4:0] unlock_cnt;
    logic ctrl_start;
    logic clr_start;
    wdg_state_t state;
    logic [13:0] cnt;
    logic rst_req;
  } wdg_regs_t;

  // Reserved and zero codes both give zero, meaning disabled.
  function automatic logic [13:0] wdg_ticks(input logic [3:0] code);
    logic [13:0] t;
    t = 14'h0000;
    if (code != 4'h0 && code <= `WDG_CODE_MAX) begin
      t = `WDG_BASE_TICKS << (code - 4'h1);
    end
    return t;
  endfunction

endpackage

//--- logic/wdg_sync_if.sv
`timescale 1ns/1ps

interface wdg_sync_if;
  logic start;
  logic busy;
  logic done;
  modport req(output start, input busy, input done);
  modport sync(input start, output busy, output done);
endinterface

//--- logic/wdg_tick.sv
`timescale 1ns/1ps
`include "wdg_consts.svh"

module wdg_tick #(
  parameter int unsigned DIV = `WDG_TICK_DIV
) (
  input wire logic aclk,
  input wire logic aresetn,
  output logic tick
);

  wdg_pkg::wdg_tick_st_t s_r;
  wdg_pkg::wdg_tick_st_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (s_r.cnt >= 16'(DIV - 1)) begin
      s_nxt.cnt = 16'h0000;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;

endmodule // wdg_tick

//--- logic/wdg_sync.sv
`timescale 1ns/1ps
`include "wdg_consts.svh"

module wdg_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  wdg_sync_if.sync port
);

  wdg_pkg::wdg_sync_st_t s_r;
  wdg_pkg::wdg_sync_st_t s_nxt;

  // Counting whole watchdog clocks from an arbitrary phase gives the
  // one to two clock delay of a real crossing.
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (!s_r.busy) begin
      if (port.start) begin
        s_nxt.busy = 1'b1;
        s_nxt.cnt = 2'h0;
      end
    end else if (tick) begin
      if (s_r.cnt == `WDG_SYNC_TICKS - 2'h1) begin
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign port.busy = s_r.busy;
  assign port.done = s_r.done;

endmodule // wdg_sync

//--- logic/wdg_top.sv
// Summary of operation
// - Lock set blocks all control writes.
// - Lock sets by one; clears only in debug.
// - Nonzero fuse period sets lock at boot.
// - Counting continues in sleep while oscillator runs.
// - Debug halt stops watchdog, zeroes counter.
// - After halt, window mode runs normal period.
// - Control write raises busy until crossed.
// - Clears take one-two ticks; extras ignored.
// - Key write opens short protected-write window.
// - Unkeyed protected writes change nothing.
// - Key guards period, window and lock.
// - Window field bits 7:4, closed length.
// - Period field bits 3:0, zero disables.
// - Period sets open window in window mode.
// - Status: lock bit 7, busy bit 0.
// - Missing clear before time-out resets system.
// - Clear inside closed window resets system.
// - Closed window starts after first clear.
// - Control resets from configuration fuse.
`timescale 1ns/1ps
`include "wdg_consts.svh"

module wdg_top #(
  parameter int unsigned ADDR_W = 8,
  parameter int unsigned TICK_DIV = `WDG_TICK_DIV
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [7:0] watchdog_config_fuse,
  input wire logic timer_clear_instruction,
  input wire logic debug_halt,
  input wire logic debug_mode,
  input wire logic osc_running,
  output logic sys_reset_req
);

  wdg_pkg::wdg_regs_t s_r;
  wdg_pkg::wdg_regs_t s_nxt;

  logic tick;
  logic ctrl_busy;
  logic unlocked;
  logic do_wr;
  logic [13:0] win_t;
  logic [13:0] per_t;
  logic [13:0] cnt_inc;
  logic count_en;
  logic per_done;
  logic win_done;
  logic ctrl_wr_ok;
  logic lock_wr_ok;
  logic clr_busy;
  logic [7:0] status_byte;
  wdg_pkg::wdg_state_t home;

  wdg_sync_if ctrl_if ();
  wdg_sync_if clr_if ();

  wdg_tick #(
    .DIV(TICK_DIV)
  ) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick)
  );

  // One crossing carries control writes, the other clear instructions;
  // each refuses a new start while it is still busy.
  wdg_sync u_ctrl_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .port(ctrl_if.sync)
  );

  wdg_sync u_clr_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .port(clr_if.sync)
  );

  assign ctrl_if.start = s_r.ctrl_start;
  assign clr_if.start = s_r.clr_start;

  // Only aligned words decode; anything else is answered with SLVERR.
  // The decode serves both the write and the read channel.
  function automatic wdg_pkg::wdg_sel_t reg_sel(input logic [ADDR_W-1:0] a);
    wdg_pkg::wdg_sel_t sel;
    sel = wdg_pkg::SEL_NONE;
    if (a[1:0] == 2'h0) begin
      if (a[ADDR_W-1:2] == (ADDR_W-2)'(`WDG_IDX_CONTROL)) begin
        sel = wdg_pkg::SEL_CTRL;
      end else if (a[ADDR_W-1:2] == (ADDR_W-2)'(`WDG_IDX_STATUS)) begin
        sel = wdg_pkg::SEL_STATUS;
      end else if (a[ADDR_W-1:2] == (ADDR_W-2)'(`WDG_IDX_UNLOCK)) begin
        sel = wdg_pkg::SEL_UNLOCK;
      end
    end
    return sel;
  endfunction

  // The start pulse is covered too, so busy reads high from the cycle
  // in which the write response rises onward with no gap.
  assign ctrl_busy = s_r.ctrl_start | ctrl_if.busy;
  assign unlocked = s_r.unlock_cnt != 5'h00;
  assign do_wr = s_r.aw_got & s_r.w_got & ~s_r.bvalid;

  // Refused writes still answer OKAY; the value simply stays. A write
  // during a crossing is dropped so the watchdog side never sees a value
  // that changed half way across.
  assign ctrl_wr_ok = s_r.wstrb0 & unlocked & ~s_r.lock & ~ctrl_busy &
                      s_r.booted;
  // The key window is not used up by a write; several may share it.
  assign lock_wr_ok = s_r.wstrb0 & unlocked;
  // The pending clear shows from the registered pulse onward.
  assign clr_busy = s_r.clr_start | clr_if.busy;

  // The counter works from the copy held on the watchdog side only.
  assign win_t = wdg_pkg::wdg_ticks(s_r.ctrl_wd[`WDG_WIN_MSB:`WDG_WIN_LSB]);
  assign per_t = wdg_pkg::wdg_ticks(s_r.ctrl_wd[`WDG_PER_MSB:`WDG_PER_LSB]);
  assign cnt_inc = s_r.cnt + 14'h0001;
  // Sleep itself does not matter; only a stopped oscillator or a debug halt stops counting.
  assign count_en = tick & osc_running;
  // A time-out ends on the tick that brings the count to its length.
  assign per_done = cnt_inc >= per_t;
  assign win_done = cnt_inc >= win_t;

  // Unused status bits read zero.
  always_comb begin
    status_byte = `WDG_STATUS_RESET;
    status_byte[`WDG_LOCK_BIT] = s_r.lock;
    status_byte[`WDG_CLR_BUSY_BIT] = clr_busy;
    status_byte[`WDG_SYNC_BUSY_BIT] = ctrl_busy;
  end

  // Where the counter starts again after a new setting or a debug halt.
  always_comb begin
    if (per_t == 14'h0000) begin
      home = wdg_pkg::ST_OFF;
    end else if (win_t != 14'h0000) begin
      home = wdg_pkg::ST_FIRST;
    end else begin
      home = wdg_pkg::ST_NORMAL;
    end
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.ctrl_start = 1'b0;
    s_nxt.clr_start = timer_clear_instruction;
    s_nxt.cfg_apply = 1'b0;
    if (unlocked) begin
      s_nxt.unlock_cnt = s_r.unlock_cnt - 5'h01;
    end

    // Fuse value is caught after reset release, not under reset.
    if (!s_r.booted) begin
      s_nxt.booted = 1'b1;
      s_nxt.ctrl = watchdog_config_fuse;
      s_nxt.ctrl_wd = watchdog_config_fuse;
      s_nxt.cfg_apply = 1'b1;
      s_nxt.lock = watchdog_config_fuse[`WDG_PER_MSB:`WDG_PER_LSB]
                   != 4'h0;
    end

    if (ctrl_if.done) begin
      s_nxt.ctrl_wd = s_r.ctrl;
      s_nxt.cfg_apply = 1'b1;
    end

    // Write channel.
    if (s_r.bvalid && bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.awready && awvalid) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.aw_sel = reg_sel(awaddr);
    end
    if (s_r.wready && wvalid) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = wdata[7:0];
      s_nxt.wstrb0 = wstrb[0];
    end
    if (do_wr) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = `WDG_RESP_OKAY;
      case (s_r.aw_sel)
        wdg_pkg::SEL_CTRL: begin
          if (ctrl_wr_ok) begin
            s_nxt.ctrl = s_r.wdata;
            s_nxt.ctrl_start = 1'b1;
          end
        end
        wdg_pkg::SEL_STATUS: begin
          if (lock_wr_ok) begin
            if (s_r.wdata[`WDG_LOCK_BIT]) begin
              s_nxt.lock = 1'b1;
            end else if (debug_mode) begin
              s_nxt.lock = 1'b0;
            end
          end
        end
        wdg_pkg::SEL_UNLOCK: begin
          if (s_r.wstrb0 && s_r.wdata == `WDG_UNLOCK_KEY) begin
            s_nxt.unlock_cnt = 5'(`WDG_UNLOCK_CYCLES);
          end
        end
        default: begin
          s_nxt.bresp = `WDG_RESP_SLVERR;
        end
      endcase
    end
    s_nxt.awready = ~s_nxt.aw_got;
    s_nxt.wready = ~s_nxt.w_got;

    // Read channel.
    if (s_r.rvalid && rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_r.arready && arvalid) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = `WDG_RESP_OKAY;
      s_nxt.rdata = 32'h0000_0000;
      case (reg_sel(araddr))
        wdg_pkg::SEL_CTRL: begin
          s_nxt.rdata[7:0] = s_r.ctrl;
        end
        wdg_pkg::SEL_STATUS: begin
          s_nxt.rdata[7:0] = status_byte;
        end
        wdg_pkg::SEL_UNLOCK: begin
          s_nxt.rdata = 32'h0000_0000;
        end
        default: begin
          s_nxt.rresp = `WDG_RESP_SLVERR;
        end
      endcase
    end
    s_nxt.arready = ~s_nxt.rvalid;

    // Time-out engine. The reset request is sticky: the reset
    // controller is expected to reset this block in turn.
    if (s_r.cfg_apply || debug_halt) begin
      s_nxt.state = home;
      s_nxt.cnt = 14'h0000;
    end else if (clr_if.done) begin
      case (s_r.state)
        wdg_pkg::ST_NORMAL: begin
          s_nxt.cnt = 14'h0000;
        end
        wdg_pkg::ST_FIRST: begin
          s_nxt.state = wdg_pkg::ST_CLOSED;
          s_nxt.cnt = 14'h0000;
        end
        wdg_pkg::ST_CLOSED: begin
          s_nxt.rst_req = 1'b1;
        end
        wdg_pkg::ST_OPEN: begin
          s_nxt.state = wdg_pkg::ST_CLOSED;
          s_nxt.cnt = 14'h0000;
        end
        default: begin
          s_nxt.cnt = 14'h0000;
        end
      endcase
    end else if (count_en) begin
      case (s_r.state)
        wdg_pkg::ST_NORMAL, wdg_pkg::ST_FIRST: begin
          s_nxt.cnt = cnt_inc;
          if (per_done) begin
            s_nxt.rst_req = 1'b1;
          end
        end
        wdg_pkg::ST_CLOSED: begin
          s_nxt.cnt = cnt_inc;
          if (win_done) begin
            s_nxt.state = wdg_pkg::ST_OPEN;
            s_nxt.cnt = 14'h0000;
          end
        end
        wdg_pkg::ST_OPEN: begin
          s_nxt.cnt = cnt_inc;
          if (per_done) begin
            s_nxt.rst_req = 1'b1;
          end
        end
        default: begin
          s_nxt.cnt = 14'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // Readies stay low through reset and rise one edge after release.
      s_r <= '0;
      s_r.state <= wdg_pkg::ST_OFF;
      s_r.ctrl <= `WDG_CONTROL_RESET;
      s_r.lock <= 1'(`WDG_STATUS_RESET >> `WDG_LOCK_BIT);
    end else begin
      s_r <= s_nxt;
    end
  end

  assign awready = s_r.awready;
  assign wready = s_r.wready;
  assign bvalid = s_r.bvalid;
  assign bresp = s_r.bresp;
  assign arready = s_r.arready;
  assign rvalid = s_r.rvalid;
  assign rresp = s_r.rresp;
  assign rdata = s_r.rdata;
  assign sys_reset_req = s_r.rst_req;

endmodule // wdg_top

//--- verif/wdg_top_properties.sv
`timescale 1ns/1ps
module wdg_chk #(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic debug_halt,
  input wire logic sys_reset_req
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_reset_sticky:
    assert property (sys_reset_req |=> sys_reset_req)
    else $error("reset request dropped");
  // Two halted cycles let any request already in flight land first.
  a_halt_quiet:
    assert property (debug_halt [*2] ##0 !sys_reset_req |=> !sys_reset_req)
    else $error("reset raised during halt");
  a_write_answer:
    assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write answer late");
  a_bresp_hold:
    assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response not held");
  a_read_answer:
    assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_rdata_hold:
    assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data not held");
  a_read_block:
    assert property (rvalid |-> !arready)
    else $error("address taken during read answer");
  a_bad_read:
    assert property (arvalid && arready && araddr >= ADDR_W'(8'h0C)
      |=> rresp == 2'h2 && rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  a_status_zero:
    assert property (arvalid && arready && araddr == ADDR_W'(8'h04)
      |=> rdata[31:8] == 24'h00_0000 && rdata[6:2] == 5'h00)
    else $error("status unused bits set");

  c_timeout: cover property (sys_reset_req);
  c_slverr: cover property (rvalid && rresp == 2'h2);
  c_halt: cover property (debug_halt && !sys_reset_req);
endmodule // wdg_chk

bind wdg_top wdg_chk #(.ADDR_W(ADDR_W)) chk (.aclk, .aresetn, .awvalid,
  .awready, .wvalid, .wready, .bvalid, .bready, .bresp, .araddr, .arvalid,
  .arready, .rvalid, .rready, .rdata, .rresp, .debug_halt, .sys_reset_req);

//--- verif/wdg_cpu.sv
`timescale 1ns/1ps
`include "wdg_consts.svh"
module wdg_cpu (
  input wire logic aclk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  output logic rready,
  output logic clr_pulse,
  output logic hung
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready, clr_pulse, hung} = '0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    hung <= (n == 64);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    rready <= 1'b0;
    hung <= (n == 64);
  endtask

  // Back-to-back writes keep the protected one well inside the key window.
  task automatic pwr(input logic [7:0] a, input logic [7:0] d);
    wr(8'h08, `WDG_UNLOCK_KEY);
    wr(a, d);
  endtask

  task automatic clr();
    @(posedge aclk);
    clr_pulse <= 1'b1;
    @(posedge aclk);
    clr_pulse <= 1'b0;
  endtask
endmodule // wdg_cpu

//--- verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, clr, halt, dbg, osc, rst, hung;
  logic [7:0] awaddr, araddr, fuse;
  logic [31:0] wdata, rdata, v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int fails, num_checks, n;

  wdg_top #(.TICK_DIV(8)) uut (.aclk, .aresetn, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .watchdog_config_fuse(fuse), .timer_clear_instruction(clr),
    .debug_halt(halt), .debug_mode(dbg), .osc_running(osc),
    .sys_reset_req(rst));
  wdg_cpu cpu (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rvalid, .rready, .clr_pulse(clr), .hung);

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge hung) begin
    fails++;
    report_and_stop();
  end

  task automatic boot(logic [7:0] f, logic o);
    @(posedge aclk);
    aresetn <= 1'b0;
    fuse <= f;
    osc <= o;
    halt <= 1'b0;
    dbg <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  task automatic idle(int c);
    repeat (c) @(posedge aclk);
  endtask

  // The request is sticky, so a late one still shows when the wait ends.
  task automatic wait_rst(int lim);
    for (n = 0; n < lim && rst !== 1'b1; n++) @(posedge aclk);
    if (n == lim) begin
      fails++;
      report_and_stop();
    end
  endtask

  task automatic t_regs();
    boot(8'h21, 1'b0);
    cpu.rd(8'h00, v);
    chk("control", 32'h0000_0021, v);
    cpu.rd(8'h04, v);
    chk("boot lock", 32'h0000_0080, v);
    cpu.pwr(8'h00, 8'h00);
    cpu.rd(8'h00, v);
    chk("locked control", 32'h0000_0021, v);
    cpu.pwr(8'h04, 8'h00);
    cpu.rd(8'h04, v);
    chk("lock kept", 32'h0000_0080, v);
    dbg <= 1'b1;
    cpu.pwr(8'h04, 8'h00);
    cpu.rd(8'h04, v);
    chk("lock cleared", 32'h0000_0000, v);
    // Let the key window run out before the unkeyed attempt.
    idle(20);
    cpu.wr(8'h00, 8'h03);
    cpu.rd(8'h00, v);
    chk("unkeyed write", 32'h0000_0021, v);
    cpu.pwr(8'h00, 8'h03);
    cpu.rd(8'h04, v);
    chk("busy set", 32'h0000_0001, v);
    for (n = 0; n < 20 && v[0] === 1'b1; n++) cpu.rd(8'h04, v);
    chk("busy clear", 32'h0000_0000, v);
    cpu.rd(8'h00, v);
    chk("new control", 32'h0000_0003, v);
    cpu.pwr(8'h04, 8'h80);
    cpu.rd(8'h04, v);
    chk("lock set", 32'h0000_0080, v);
    chk("write resp", 32'h0000_0000, 32'(bresp));
    cpu.rd(8'h10, v);
    chk("unmapped", 32'h0000_0000, v);
    chk("unmapped resp", 32'h0000_0002, 32'(rresp));
    cpu.wr(8'h10, 8'h00);
    chk("unmapped write", 32'h0000_0002, 32'(bresp));
    chk("stopped osc", 32'h0000_0000, 32'(rst));
    $display("register test done");
  endtask

  task automatic t_normal();
    boot(8'h01, 1'b1);
    repeat (4) begin
      cpu.clr();
      idle(28);
    end
    idle(20);
    chk("clears restart", 32'h0000_0000, 32'(rst));
    wait_rst(80);
    chk("time-out", 32'h0000_0001, 32'(rst));
    $display("normal test done");
  endtask

  task automatic t_window();
    boot(8'h11, 1'b1);
    cpu.clr();
    idle(3);
    cpu.clr();
    idle(28);
    chk("first clear", 32'h0000_0000, 32'(rst));
    cpu.clr();
    wait_rst(60);
    chk("closed clear", 32'h0000_0001, 32'(rst));
    $display("window test done");
  endtask

  // Closed window 8 ticks, open window 16 ticks; a clear in the open
  // window starts a new closed one.
  task automatic t_open();
    boot(8'h12, 1'b1);
    cpu.clr();
    idle(100);
    cpu.clr();
    idle(170);
    chk("open window", 32'h0000_0000, 32'(rst));
    wait_rst(80);
    chk("open time-out", 32'h0000_0001, 32'(rst));
    $display("open window test done");
  endtask

  task automatic t_halt();
    boot(8'h32, 1'b1);
    idle(100);
    halt <= 1'b1;
    idle(20);
    halt <= 1'b0;
    idle(60);
    chk("halt zeroes", 32'h0000_0000, 32'(rst));
    cpu.clr();
    idle(40);
    chk("closed skipped", 32'h0000_0000, 32'(rst));
    $display("halt test done");
  endtask

  task automatic t_reserved();
    boot(8'hCC, 1'b1);
    cpu.clr();
    idle(300);
    chk("reserved codes", 32'h0000_0000, 32'(rst));
    $display("reserved test done");
  endtask

  initial begin
    aresetn = 1'b0;
    fuse = 8'h00;
    osc = 1'b0;
    halt = 1'b0;
    dbg = 1'b0;
    t_regs();
    t_normal();
    t_window();
    t_open();
    t_halt();
    t_reserved();
    report_and_stop();
  end
endmodule // testbench
